//--- core/dsc_device.sv
// device end: sleep entry, wake and reset exit of the power state
`timescale 1ns/1ps
`default_nettype none
module dsc_device #(
  parameter int unsigned ENTRY_CYC =
    dsc_pkg::SLEEP_ENTRY_CYC - dsc_pkg::SYNC_LAT,
  parameter int unsigned WAKE_CYC =
    dsc_pkg::WAKE_CYC - dsc_pkg::SYNC_LAT
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // serial link
  dsc_link_if.device      link,
  // core side
  input  wire logic       array_busy,
  output logic            deep_sleep_state,
  output logic            operation_in_progress_flag,
  output logic            soft_reset_pulse,
  output logic            por_reset_pulse,
  output logic            cmd_strobe,
  output logic [7:0]      cmd_code
);
  localparam int unsigned TW = dsc_pkg::TIMER_W;

  if (ENTRY_CYC < 1 || ENTRY_CYC >= (1 << TW) ||
      WAKE_CYC < 1 || WAKE_CYC >= (1 << TW)) begin : g_bad_delay
    $error("delay counts do not fit the timer");
  end

  // pin synchronisers
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic mosi_meta;
  logic mosi_sync;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_meta   <= 1'b1;
      cs_sync   <= 1'b1;
      cs_prev   <= 1'b1;
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      mosi_meta <= 1'b0;
      mosi_sync <= 1'b0;
    end else begin
      cs_meta   <= link.cs_n;
      cs_sync   <= cs_meta;
      cs_prev   <= cs_sync;
      sclk_meta <= link.sclk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      mosi_meta <= link.mosi;
      mosi_sync <= mosi_meta;
    end
  end

  wire sclk_rise = !cs_sync && sclk_sync && !sclk_prev;
  wire sclk_fall = !cs_sync && !sclk_sync && sclk_prev;
  wire cs_fall   = !cs_sync && cs_prev;
  wire cs_rise   = cs_sync && !cs_prev;

  // frame shifter
  logic [5:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] cmd_reg;
  logic       status_mode;
  logic [7:0] status_sh;
  logic       miso_q;

  wire [7:0] next_shift = {shift_in[6:0], mosi_sync};
  wire [5:0] next_cnt   = (bit_cnt == 6'h3F) ? bit_cnt : bit_cnt + 6'h01;
  wire byte_done = sclk_rise &&
                   (bit_cnt == 6'(dsc_pkg::CMD_BITS - 1));
  wire frame_ok  = cs_rise &&
                   (bit_cnt == 6'(dsc_pkg::CMD_BITS));
  wire frame_any = cs_rise && (bit_cnt >= 6'(dsc_pkg::CMD_BITS));

  // power state
  dsc_pkg::dsc_pwr_t state;
  dsc_pkg::dsc_pwr_t next_state;
  logic [TW-1:0]     timer;
  logic [TW-1:0]     next_timer;
  logic              reset_armed;
  logic              next_armed;
  logic              next_soft;
  logic              next_por;
  logic              next_fwd;

  wire is_sleep_cmd = shift_in == dsc_pkg::CMD_SLEEP;
  wire is_wake_cmd  = shift_in == dsc_pkg::CMD_WAKE;
  wire busy_now     = array_busy || (state == dsc_pkg::DSC_WAKING);
  wire serve_status = byte_done &&
                      (next_shift == dsc_pkg::CMD_GET_FEAT) &&
                      (state == dsc_pkg::DSC_STANDBY ||
                       state == dsc_pkg::DSC_WAKING);
  wire fwd_ok       = (cmd_reg != dsc_pkg::CMD_SLEEP) &&
                      (cmd_reg != dsc_pkg::CMD_WAKE);

  always_comb begin
    next_state = state;
    next_timer = (timer != '0) ? timer - TW'(1) : timer;
    next_armed = reset_armed;
    next_soft  = 1'b0;
    next_por   = 1'b0;
    next_fwd   = 1'b0;
    unique case (state)
      dsc_pkg::DSC_STANDBY: begin
        // a frame end alone never leaves standby
        if (frame_ok && is_sleep_cmd && !array_busy) begin
          next_state = dsc_pkg::DSC_ENTERING;
          next_timer = TW'(ENTRY_CYC - 1);
        end else if (frame_any && fwd_ok) begin
          next_fwd = 1'b1;
        end
      end
      dsc_pkg::DSC_ENTERING: begin
        if (timer == '0) begin
          next_state  = dsc_pkg::DSC_SLEEP;
          next_armed  = 1'b0;
        end
      end
      dsc_pkg::DSC_SLEEP: begin
        if (frame_ok) begin
          next_armed = 1'b0;
          if (is_wake_cmd && !busy_now) begin
            next_state = dsc_pkg::DSC_WAKING;
            next_timer = TW'(WAKE_CYC - 1);
          end else if (shift_in == dsc_pkg::CMD_SOFT_RESET) begin
            next_state = dsc_pkg::DSC_STANDBY;
            next_soft  = 1'b1;
          end else if (shift_in == dsc_pkg::CMD_RESET_EN) begin
            next_armed = 1'b1;
          end else if (shift_in == dsc_pkg::CMD_RESET && reset_armed) begin
            next_state = dsc_pkg::DSC_STANDBY;
            next_por   = 1'b1;
          end
        end else if (frame_any) begin
          next_armed = 1'b0;
        end
      end
      dsc_pkg::DSC_WAKING: begin
        // frames other than status reads are dropped until the delay ends
        if (timer == '0) begin
          next_state = dsc_pkg::DSC_STANDBY;
        end
      end
      default: begin
        next_state = dsc_pkg::DSC_STANDBY;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= dsc_pkg::DSC_STANDBY;
      timer       <= '0;
      reset_armed <= 1'b0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      reset_armed <= next_armed;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt  <= '0;
      shift_in <= '0;
      cmd_reg  <= '0;
    end else if (cs_fall) begin
      bit_cnt  <= '0;
    end else if (sclk_rise) begin
      bit_cnt  <= next_cnt;
      if (bit_cnt < 6'(dsc_pkg::CMD_BITS)) begin
        shift_in <= next_shift;
      end
      if (byte_done) begin
        cmd_reg <= next_shift;
      end
    end
  end

  // status byte, shifted out on falling link clock edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_mode <= 1'b0;
      status_sh   <= '0;
      miso_q      <= 1'b0;
    end else if (cs_rise || cs_fall) begin
      status_mode <= 1'b0;
      miso_q      <= 1'b0;
    end else begin
      if (serve_status) begin
        status_mode <= 1'b1;
      end
      if (sclk_rise &&
          bit_cnt == 6'(dsc_pkg::STATUS_FIRST - 1)) begin
        status_sh <= 8'(busy_now) << dsc_pkg::STAT_FLAG_BIT;
      end
      if (sclk_fall && status_mode &&
          bit_cnt >= 6'(dsc_pkg::STATUS_FIRST) &&
          bit_cnt <= 6'(dsc_pkg::STATUS_LAST)) begin
        miso_q    <= status_sh[7];
        status_sh <= {status_sh[6:0], 1'b0};
      end
    end
  end

  assign link.miso = miso_q;

  // registered core side outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      deep_sleep_state           <= 1'b0;
      operation_in_progress_flag <= 1'b0;
      soft_reset_pulse           <= 1'b0;
      por_reset_pulse            <= 1'b0;
      cmd_strobe                 <= 1'b0;
      cmd_code                   <= '0;
    end else begin
      deep_sleep_state           <= next_state == dsc_pkg::DSC_SLEEP;
      operation_in_progress_flag <= array_busy ||
                                    next_state == dsc_pkg::DSC_WAKING;
      soft_reset_pulse           <= next_soft;
      por_reset_pulse            <= next_por;
      cmd_strobe                 <= next_fwd;
      if (next_fwd) begin
        cmd_code <= cmd_reg;
      end
    end
  end
endmodule : dsc_device
`default_nettype wire

//--- core/dsc_host.sv
// host end: frames sleep, wake, reset and status commands
`timescale 1ns/1ps
`default_nettype none
module dsc_host #(
  parameter int unsigned HALF_CYC   = dsc_pkg::SCLK_HALF_CYC,
  parameter int unsigned ENTRY_HOLD =
    dsc_pkg::SLEEP_ENTRY_CYC + dsc_pkg::SYNC_LAT,
  parameter int unsigned WAKE_HOLD  =
    dsc_pkg::WAKE_CYC + dsc_pkg::SYNC_LAT,
  parameter int unsigned SETTLE_CYC = dsc_pkg::SETTLE_CYC
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  // user side
  input  wire logic            req,
  input  wire dsc_pkg::dsc_op_t req_op,
  output logic                 ready,
  output logic                 done,
  output logic [7:0]           status_byte,
  // serial link
  dsc_link_if.host             link
);
  localparam int unsigned TW = dsc_pkg::TIMER_W;

  if (HALF_CYC < 2 || HALF_CYC > (1 << TW) ||
      ENTRY_HOLD < 1 || ENTRY_HOLD >= (1 << TW) ||
      WAKE_HOLD < 1 || WAKE_HOLD >= (1 << TW) ||
      SETTLE_CYC < 1 || SETTLE_CYC >= (1 << TW)) begin : g_bad_time
    $error("host timing parameters out of range");
  end

  logic miso_meta;
  logic miso_sync;
  dsc_pkg::dsc_hst_t state;
  logic [TW-1:0] timer;
  logic [TW-1:0] hold;
  logic [23:0]   tx_sh;
  logic [4:0]    bits_left;
  logic [7:0]    rx_sh;
  logic          por_first;
  logic          is_status;
  logic          cs_q;
  logic          sclk_q;
  logic          mosi_q;

  wire tick = timer == '0;
  wire [TW-1:0] half = TW'(HALF_CYC - 1);
  wire [7:0] op_byte =
    (req_op == dsc_pkg::DSC_OP_SLEEP) ? dsc_pkg::CMD_SLEEP :
    (req_op == dsc_pkg::DSC_OP_WAKE)  ? dsc_pkg::CMD_WAKE :
    (req_op == dsc_pkg::DSC_OP_SOFT)  ? dsc_pkg::CMD_SOFT_RESET :
    (req_op == dsc_pkg::DSC_OP_POR)   ? dsc_pkg::CMD_RESET_EN :
                                        dsc_pkg::CMD_GET_FEAT;
  wire op_stat = req_op == dsc_pkg::DSC_OP_STATUS;
  wire [TW-1:0] op_hold =
    (req_op == dsc_pkg::DSC_OP_SLEEP) ? TW'(ENTRY_HOLD) :
    (req_op == dsc_pkg::DSC_OP_WAKE)  ? TW'(WAKE_HOLD) :
    (req_op == dsc_pkg::DSC_OP_POR)   ? TW'(SETTLE_CYC) :
                                        TW'(dsc_pkg::GAP_CYC);
  wire [23:0] op_frame = {op_byte,
                          op_stat ? dsc_pkg::STATUS_ADDR : 8'h00, 8'h00};
  wire [4:0] op_bits = op_stat ? 5'(dsc_pkg::STATUS_BITS) :
                                 5'(dsc_pkg::CMD_BITS);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
    end else begin
      miso_meta <= link.miso;
      miso_sync <= miso_meta;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= dsc_pkg::DSC_H_IDLE;
      timer       <= '0;
      hold        <= '0;
      tx_sh       <= '0;
      bits_left   <= '0;
      rx_sh       <= '0;
      por_first   <= 1'b0;
      is_status   <= 1'b0;
      cs_q        <= 1'b1;
      sclk_q      <= 1'b0;
      mosi_q      <= 1'b0;
      ready       <= 1'b1;
      done        <= 1'b0;
      status_byte <= '0;
    end else begin
      done  <= 1'b0;
      timer <= tick ? timer : timer - TW'(1);
      unique case (state)
        dsc_pkg::DSC_H_IDLE: begin
          if (req) begin
            ready     <= 1'b0;
            tx_sh     <= op_frame;
            bits_left <= op_bits;
            hold      <= op_hold;
            por_first <= req_op == dsc_pkg::DSC_OP_POR;
            is_status <= op_stat;
            cs_q      <= 1'b0;
            mosi_q    <= op_frame[23];
            timer     <= half;
            state     <= dsc_pkg::DSC_H_LEAD;
          end
        end
        dsc_pkg::DSC_H_LEAD, dsc_pkg::DSC_H_LOW: begin
          if (tick) begin
            timer <= half;
            if (bits_left == '0) begin
              cs_q  <= 1'b1;
              timer <= por_first ? TW'(dsc_pkg::GAP_CYC) : hold;
              state <= por_first ? dsc_pkg::DSC_H_GAP :
                                   dsc_pkg::DSC_H_WAIT;
            end else begin
              sclk_q <= 1'b1;
              state  <= dsc_pkg::DSC_H_HIGH;
            end
          end
        end
        dsc_pkg::DSC_H_HIGH: begin
          if (tick) begin
            rx_sh     <= {rx_sh[6:0], miso_sync};
            sclk_q    <= 1'b0;
            tx_sh     <= {tx_sh[22:0], 1'b0};
            mosi_q    <= tx_sh[22];
            bits_left <= bits_left - 5'h01;
            timer     <= half;
            state     <= dsc_pkg::DSC_H_LOW;
          end
        end
        dsc_pkg::DSC_H_GAP: begin
          if (tick) begin
            por_first <= 1'b0;
            tx_sh     <= {dsc_pkg::CMD_RESET, 16'h0000};
            bits_left <= 5'(dsc_pkg::CMD_BITS);
            mosi_q    <= dsc_pkg::CMD_RESET[7];
            cs_q      <= 1'b0;
            timer     <= half;
            state     <= dsc_pkg::DSC_H_LEAD;
          end
        end
        dsc_pkg::DSC_H_WAIT: begin
          if (tick) begin
            done  <= 1'b1;
            ready <= 1'b1;
            if (is_status) begin
              status_byte <= rx_sh;
            end
            state <= dsc_pkg::DSC_H_IDLE;
          end
        end
        default: begin
          state <= dsc_pkg::DSC_H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;
endmodule : dsc_host
`default_nettype wire

//--- core/dsc_link_if.sv
// serial link between the host controller and the device
`timescale 1ns/1ps
`default_nettype none
interface dsc_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport device (input cs_n, input sclk, input mosi, output miso);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : dsc_link_if
`default_nettype wire

//--- core/dsc_pkg.sv
// shared constants and types for the deep sleep control link
`default_nettype none
package dsc_pkg;
  // core clock
  localparam int unsigned CORE_CLK_PERIOD_NS   = 100;
  // link clock made by the host
  localparam int unsigned SCLK_PERIOD_NS       = 800;
  localparam int unsigned SCLK_HALF_CYC        =
    SCLK_PERIOD_NS / 2 / CORE_CLK_PERIOD_NS;
  // timing, longest times round down, least times round up
  localparam int unsigned SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int unsigned WAKE_DELAY_NS        = 30000;
  localparam int unsigned POWER_SETTLE_TIME_US = 2000;
  localparam int unsigned SLEEP_ENTRY_CYC      =
    SLEEP_ENTRY_DELAY_NS / CORE_CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC             =
    WAKE_DELAY_NS / CORE_CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYC           =
    (POWER_SETTLE_TIME_US * 1000 + CORE_CLK_PERIOD_NS - 1) /
    CORE_CLK_PERIOD_NS;
  // latency of the pin synchronisers, in core cycles
  localparam int unsigned SYNC_LAT             = 3;
  // short chip select high time between frames
  localparam int unsigned GAP_CYC              = 4;
  localparam int unsigned TIMER_W              = 16;
  // command bytes
  localparam logic [7:0] CMD_SLEEP      = 8'hB9;
  localparam logic [7:0] CMD_WAKE       = 8'hAB;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hFF;
  localparam logic [7:0] CMD_RESET_EN   = 8'h66;
  localparam logic [7:0] CMD_RESET      = 8'h99;
  localparam logic [7:0] CMD_GET_FEAT   = 8'h0F;
  localparam logic [7:0] STATUS_ADDR    = 8'hC0;
  // frame lengths and status bit positions, in bits
  localparam int unsigned CMD_BITS      = 8;
  localparam int unsigned STATUS_BITS   = 24;
  localparam int unsigned STATUS_FIRST  = 16;
  localparam int unsigned STATUS_LAST   = 23;
  // status byte layout
  localparam int unsigned STAT_FLAG_BIT = 0;

  typedef enum logic [3:0] {
    DSC_STANDBY  = 4'b0001,
    DSC_ENTERING = 4'b0010,
    DSC_SLEEP    = 4'b0100,
    DSC_WAKING   = 4'b1000
  } dsc_pwr_t;

  typedef enum logic [5:0] {
    DSC_H_IDLE = 6'b00_0001,
    DSC_H_LEAD = 6'b00_0010,
    DSC_H_HIGH = 6'b00_0100,
    DSC_H_LOW  = 6'b00_1000,
    DSC_H_GAP  = 6'b01_0000,
    DSC_H_WAIT = 6'b10_0000
  } dsc_hst_t;

  typedef enum logic [2:0] {
    DSC_OP_SLEEP  = 3'h0,
    DSC_OP_WAKE   = 3'h1,
    DSC_OP_SOFT   = 3'h2,
    DSC_OP_POR    = 3'h3,
    DSC_OP_STATUS = 3'h4
  } dsc_op_t;
endpackage : dsc_pkg
`default_nettype wire

//--- verif/dsc_properties.sv
// concurrent checks on the deep sleep link and the device outputs
`timescale 1ns/1ps
`default_nettype none
module dsc_properties #(
  parameter int unsigned ENTRY_CYC =
    dsc_pkg::SLEEP_ENTRY_CYC - dsc_pkg::SYNC_LAT,
  parameter int unsigned WAKE_CYC  =
    dsc_pkg::WAKE_CYC - dsc_pkg::SYNC_LAT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic miso,
  // device side
  input wire logic array_busy,
  input wire logic deep_sleep_state,
  input wire logic operation_in_progress_flag,
  input wire logic soft_reset_pulse,
  input wire logic por_reset_pulse,
  input wire logic cmd_strobe
);
  logic [15:0] hi_cnt;
  logic [15:0] wk_cnt;
  logic        busy_d;
  wire  [15:0] next_hi_cnt = cs_n ? hi_cnt + 16'h0001 : 16'h0000;
  wire  [15:0] next_wk_cnt = !operation_in_progress_flag ? 16'h0000 :
    (busy_d ? wk_cnt : wk_cnt + 16'h0001);
  wire         pulse_any   = soft_reset_pulse || por_reset_pulse;

  // cycles since chip select rose, wake cycles not caused by the array
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt <= 16'h0000;
      wk_cnt <= 16'h0000;
      busy_d <= 1'b0;
    end else begin
      hi_cnt <= next_hi_cnt;
      wk_cnt <= next_wk_cnt;
      busy_d <= array_busy;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_entry_delay: assert property ($rose(deep_sleep_state) |->
    hi_cnt >= ENTRY_CYC && hi_cnt <= ENTRY_CYC + 3)
    else $error("sleep entry delay out of range");
  a_wake_length: assert property ($fell(operation_in_progress_flag) &&
    wk_cnt > 16'h0001 |-> wk_cnt >= WAKE_CYC - 1 && wk_cnt <= WAKE_CYC + 1)
    else $error("wake delay length wrong");
  a_wake_cs_high: assert property (
    operation_in_progress_flag && !busy_d |-> cs_n)
    else $error("chip select low during wake delay");
  a_asleep_no_cmd: assert property (
    deep_sleep_state && $past(deep_sleep_state) |-> !cmd_strobe)
    else $error("command accepted while asleep");
  a_exit_cause: assert property ($fell(deep_sleep_state) |-> ##[0:1]
    (operation_in_progress_flag || pulse_any || $past(pulse_any)))
    else $error("sleep left without wake or reset");
  a_soft_exit: assert property (soft_reset_pulse |->
    $past(deep_sleep_state) ##1 !deep_sleep_state)
    else $error("soft reset pulse without sleep exit");
  a_por_exit: assert property (por_reset_pulse |->
    $past(deep_sleep_state) ##1 !deep_sleep_state)
    else $error("reset pair pulse without sleep exit");
  a_sleep_stays: assert property (
    deep_sleep_state && hi_cnt > 16'h0008 |=> deep_sleep_state)
    else $error("sleep left while deselected");
  a_idle_sclk: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("link clock not idle low");

  c_sleep: cover property ($rose(deep_sleep_state));
  c_wake: cover property ($fell(operation_in_progress_flag) && wk_cnt > 1);
  c_soft: cover property (soft_reset_pulse);
  c_por: cover property (por_reset_pulse);
endmodule : dsc_properties
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the deep sleep host and device pair
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned EC = 5;
  localparam int unsigned WC = 20;
  logic              core_clk = 1'b0;
  logic              arst_n   = 1'b0;
  logic              req      = 1'b0;
  dsc_pkg::dsc_op_t  req_op   = dsc_pkg::DSC_OP_STATUS;
  logic              busy1    = 1'b0;
  logic              busy2    = 1'b0;
  logic              sclk_q   = 1'b0;
  logic [31:0]       seed     = 32'h9139_5197;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                nbits    = 0;
  int                last_bits = 0;
  wire               ready, done, ds1, flag1, soft1, por1, strb1;
  wire               ds2, flag2, soft2, por2, strb2;
  wire [7:0]         stat, code1, code2;

  dsc_link_if lnk ();
  dsc_link_if lnk2 ();

  always #50 core_clk = ~core_clk;

  dsc_host #(.ENTRY_HOLD(EC + 3), .WAKE_HOLD(WC + 3), .SETTLE_CYC(50))
    i_dsc_host (.core_clk(core_clk), .arst_n(arst_n), .req(req),
    .req_op(req_op), .ready(ready), .done(done), .status_byte(stat),
    .link(lnk.host));
  dsc_device #(.ENTRY_CYC(EC), .WAKE_CYC(WC)) i_dsc_device (
    .core_clk(core_clk), .arst_n(arst_n), .link(lnk.device),
    .array_busy(busy1), .deep_sleep_state(ds1),
    .operation_in_progress_flag(flag1), .soft_reset_pulse(soft1),
    .por_reset_pulse(por1), .cmd_strobe(strb1), .cmd_code(code1));
  dsc_device #(.ENTRY_CYC(EC), .WAKE_CYC(WC)) i_dsc_device_2 (
    .core_clk(core_clk), .arst_n(arst_n), .link(lnk2.device),
    .array_busy(busy2), .deep_sleep_state(ds2),
    .operation_in_progress_flag(flag2), .soft_reset_pulse(soft2),
    .por_reset_pulse(por2), .cmd_strobe(strb2), .cmd_code(code2));
  dsc_properties #(.ENTRY_CYC(EC), .WAKE_CYC(WC)) i_dsc_properties (
    .core_clk(core_clk), .arst_n(arst_n), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .miso(lnk.miso), .array_busy(busy1),
    .deep_sleep_state(ds1), .operation_in_progress_flag(flag1),
    .soft_reset_pulse(soft1), .por_reset_pulse(por1), .cmd_strobe(strb1));

  // link clock rises per frame on the host link
  always @(posedge core_clk) begin
    sclk_q <= lnk.sclk;
    if (!lnk.cs_n && lnk.sclk && !sclk_q) nbits <= nbits + 1;
    if (lnk.cs_n && nbits != 0) begin
      last_bits <= nbits;
      nbits <= 0;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // expected sleep state after one host operation
  function automatic logic exp_sleep(input logic cur,
                                     input dsc_pkg::dsc_op_t o,
                                     input logic b);
    case (o)
      dsc_pkg::DSC_OP_SLEEP: return cur | ~b;
      dsc_pkg::DSC_OP_WAKE:  return cur & b;
      dsc_pkg::DSC_OP_SOFT,
      dsc_pkg::DSC_OP_POR:   return 1'b0;
      default:               return cur;
    endcase
  endfunction : exp_sleep

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic op(input dsc_pkg::dsc_op_t o);
    int i;
    tick(1);
    req = 1'b1;
    req_op = o;
    tick(1);
    req = 1'b0;
    for (i = 0; i < 4000 && done !== 1'b1; i++) tick(1);
    if (i == 4000) begin
      n_errors++;
      results();
    end
  endtask : op

  // bench drives the second link, free to break the framing
  task automatic frame(input logic [7:0] b, input int n);
    int k;
    lnk2.cs_n = 1'b0;
    for (k = 0; k < n; k++) begin
      lnk2.mosi = b[7 - (k % 8)];
      tick(4);
      lnk2.sclk = 1'b1;
      tick(4);
      lnk2.sclk = 1'b0;
    end
    tick(4);
    lnk2.cs_n = 1'b1;
    lnk2.mosi = ~lnk2.mosi;
    tick(8);
  endtask : frame

  task automatic step2(input logic [7:0] b, input int n, input logic bz,
                       input logic e);
    busy2 = bz;
    frame(b, n);
    tick(WC + 10);
    chk_bit("ds2", e, ds2);
    busy2 = 1'b0;
  endtask : step2

  task automatic results();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  initial begin
    lnk2.cs_n = 1'b1;
    lnk2.sclk = 1'b0;
    lnk2.mosi = 1'b0;
  end

  initial begin
    int               j;
    dsc_pkg::dsc_op_t o;
    logic             e;
    logic             ds_exp;
    tick(2);
    arst_n = 1'b1;
    chk_bit("ds1", 1'b0, ds1);
    chk_bit("ready", 1'b1, ready);
    op(dsc_pkg::DSC_OP_SLEEP);
    chk_bit("ds1", 1'b1, ds1);
    chk_byte("bits", 8'h08, 8'(last_bits));
    op(dsc_pkg::DSC_OP_STATUS);
    chk_bit("ds1", 1'b1, ds1);
    op(dsc_pkg::DSC_OP_WAKE);
    chk_byte("bits", 8'h08, 8'(last_bits));
    chk_bit("ds1", 1'b0, ds1);
    chk_bit("flag1", 1'b0, flag1);
    busy1 = 1'b1;
    op(dsc_pkg::DSC_OP_SLEEP);
    chk_bit("ds1", 1'b0, ds1);
    op(dsc_pkg::DSC_OP_STATUS);
    chk_bit("stat", 1'b1, stat[dsc_pkg::STAT_FLAG_BIT]);
    chk_byte("code1", dsc_pkg::CMD_GET_FEAT, code1);
    busy1 = 1'b0;
    op(dsc_pkg::DSC_OP_SLEEP);
    busy1 = 1'b1;
    op(dsc_pkg::DSC_OP_WAKE);
    chk_bit("ds1", 1'b1, ds1);
    busy1 = 1'b0;
    op(dsc_pkg::DSC_OP_SOFT);
    chk_bit("ds1", 1'b0, ds1);
    op(dsc_pkg::DSC_OP_SLEEP);
    op(dsc_pkg::DSC_OP_POR);
    chk_bit("ds1", 1'b0, ds1);
    ds_exp = 1'b0;
    for (j = 0; j < 24; j++) begin
      seed = xs(seed);
      o = dsc_pkg::dsc_op_t'(seed[10:8] % 3'd5);
      busy1 = seed[0] & seed[1];
      e = exp_sleep(ds_exp, o, busy1);
      op(o);
      ds_exp = e;
      chk_bit("ds1", e, ds1);
      if (o == dsc_pkg::DSC_OP_STATUS && !e)
        chk_bit("stat", busy1, stat[dsc_pkg::STAT_FLAG_BIT]);
    end
    busy1 = 1'b0;
    step2(8'hB9, 7, 1'b0, 1'b0);
    step2(8'hB9, 9, 1'b0, 1'b0);
    step2(8'h06, 8, 1'b0, 1'b0);
    chk_byte("code2", 8'h06, code2);
    step2(8'hB9, 8, 1'b1, 1'b0);
    step2(8'hB9, 8, 1'b0, 1'b1);
    step2(8'h06, 8, 1'b0, 1'b1);
    step2(8'h66, 8, 1'b0, 1'b1);
    step2(8'h99, 8, 1'b0, 1'b0);
    tick(dsc_pkg::SETTLE_CYC);
    step2(8'hB9, 8, 1'b0, 1'b1);
    step2(8'h66, 8, 1'b0, 1'b1);
    step2(8'h06, 8, 1'b0, 1'b1);
    step2(8'h99, 8, 1'b0, 1'b1);
    frame(8'hAB, 8);
    chk_bit("flag2", 1'b1, flag2);
    tick(WC + 10);
    chk_bit("ds2", 1'b0, ds2);
    chk_bit("flag2", 1'b0, flag2);
    op(dsc_pkg::DSC_OP_SLEEP);
    arst_n = 1'b0;
    tick(2);
    chk_bit("ds1", 1'b0, ds1);
    arst_n = 1'b1;
    op(dsc_pkg::DSC_OP_SLEEP);
    chk_bit("ds1", 1'b1, ds1);
    results();
  end
endmodule : tb
`default_nettype wire
